// file: rtl/acr_top.sv
// Notes on behaviour
// R1: result high byte is read-only, resets zero, shows result bits 11:4.
// R2: result bits below the decimation-chosen resolution are forced to zero.
// R3: done flag bit 7 sets on conversion end, clears on result high read.
// R4: a further conversion before that read just keeps the done flag set.
// R5: writing go with trigger select 11 starts a sequence only when idle.
// R6: go reads 1 while its started sequence runs, 0 otherwise.
// R7: trigger select 5:4, reset 11: 00 pin, 10 timer compare, 11 go.
// R8: trigger select 01 runs full speed, no trigger awaited.
// R9: writing 01 to bits 3:2 steps the LFSR once 13x, then back to 00.
// R10: reference select 7:6, reset 00, drives the sequence reference choice.
// R11: decimation select 5:4, reset 01: 64, 128, 256 or 512.
// R12: end channel 3:0 picks last input, pair or fixed source.
// R13: end codes up to 0111 convert singles from input zero to the end.
// R14: end codes 1000 to 1011 convert pairs from the first to the end.
// R15: end codes 1100 and up do one conversion of that source.
// R16: end channel reads back the most recent conversion; below 1100 the code gives that channel plus one.
// R17: after a sequence below 1100 the readback is written value plus one.
// R18: hardware clears go once the sequence completes.
// R19: in full speed a new sequence starts at the previous one's end.
// R20: software writes 11 into the reserved low bits of control one.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "acr_consts.svh"

module acr_top #(
    parameter int LFSR_UNROLL = `ACR_LFSR_UNROLL,
    parameter logic [15:0] LFSR_SEED = `ACR_LFSR_SEED,
    parameter logic [15:0] LFSR_TAPS = `ACR_LFSR_TAPS
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire acr_pkg::acr_bus_req_type bus_req_i,
    output logic [7:0] rdata_o,
    input wire logic external_trigger_pin_i,
    input wire logic timer_compare_i,
    input wire acr_pkg::acr_conv_res_type conv_res_i,
    output acr_pkg::acr_conv_cfg_type conv_cfg_o,
    output logic conv_start_o,
    output logic seq_busy_o,
    output logic sample_ready_o,
    output logic [11:0] result_o,
    output logic [15:0] random_o
);

    acr_pkg::acr_state_type state_r;
    acr_pkg::acr_state_type state_nxt;

    logic wr_ctl_one;
    logic wr_ctl_two;
    logic rd_result_high;
    logic pin_edge;
    logic go_start;
    logic trig_start;
    logic seq_last;
    logic rnd_step;

    // first channel of a sequence for a given end code
    function automatic logic [3:0] first_channel(input logic [3:0] end_ch);
        if (end_ch <= `ACR_CH_LAST_SINGLE) begin
            first_channel = `ACR_CH_FIRST_SINGLE; // R13
        end else if (end_ch < `ACR_CH_FIRST_FIXED) begin
            first_channel = `ACR_CH_FIRST_PAIR; // R14
        end else begin
            first_channel = end_ch; // R15
        end
    endfunction : first_channel

    // readback value after a finished conversion: its channel, plus one below 1100
    function automatic logic [3:0] readback_of(input logic [3:0] ch);
        if (ch < `ACR_CH_FIRST_FIXED) begin
            readback_of = ch + `ACR_CH_STEP; // R17
        end else begin
            readback_of = ch;
        end
    endfunction : readback_of

    // keep only the bits that the decimation rate makes meaningful
    function automatic logic [11:0] resolution_mask(input logic [1:0] dec);
        int bits;
        case (dec)
            `ACR_DEC_64: bits = `ACR_RES_BITS_64;
            `ACR_DEC_128: bits = `ACR_RES_BITS_128;
            `ACR_DEC_256: bits = `ACR_RES_BITS_256;
            default: bits = `ACR_RES_BITS_512;
        endcase
        resolution_mask = '0;
        for (int i = 0; i < `ACR_RES_WIDTH; i++) begin
            if (i >= `ACR_RES_WIDTH - bits) begin
                resolution_mask[i] = 1'b1;
            end
        end
    endfunction : resolution_mask

    // bus decode; a stray address is simply ignored
    assign wr_ctl_one = bus_req_i.wr && (bus_req_i.addr == `ACR_ADDR_CTL_ONE);
    assign wr_ctl_two = bus_req_i.wr && (bus_req_i.addr == `ACR_ADDR_CTL_TWO);
    assign rd_result_high = bus_req_i.rd && (bus_req_i.addr == `ACR_ADDR_RESULT_HIGH);

    // pin edge only once the last two sync stages agree
    assign pin_edge = (state_r.pin_sync[1] == state_r.pin_sync[2]) &&
                      state_r.pin_sync[2] && !state_r.pin_level;

    // go only counts when its own write also selects the go trigger
    assign go_start = wr_ctl_one && bus_req_i.wdata[`ACR_GO_BIT] &&
                      (bus_req_i.wdata[`ACR_TRIG_HI:`ACR_TRIG_LO] == `ACR_TRIG_GO) &&
                      (state_r.seq == acr_pkg::ACR_IDLE); // R5

    // hardware start events while idle
    always_comb begin
        case (state_r.trig_sel)
            `ACR_TRIG_PIN: trig_start = pin_edge; // R7
            `ACR_TRIG_FULL: trig_start = 1'b1; // R8
            `ACR_TRIG_TIMER: trig_start = timer_compare_i; // R7
            default: trig_start = 1'b0;
        endcase
    end

    // sequence ends on the programmed channel, fixed sources at once
    assign seq_last = (state_r.cursor == state_r.end_channel) ||
                      (state_r.end_channel >= `ACR_CH_FIRST_FIXED); // R15

    assign rnd_step = (state_r.rnd_ctl == `ACR_RND_STEP); // R9

    // next state of the whole block
    always_comb begin
        state_nxt = state_r;
        state_nxt.conv_start = 1'b0;
        state_nxt.sample_ready = 1'b0;
        state_nxt.rdata = `ACR_BYTE_ZERO;

        // three-stage pin synchroniser
        state_nxt.pin_sync = {state_r.pin_sync[1:0], external_trigger_pin_i};
        if (state_r.pin_sync[1] == state_r.pin_sync[2]) begin
            state_nxt.pin_level = state_r.pin_sync[2];
        end

        // register reads answer in the following cycle only
        if (bus_req_i.rd) begin
            case (bus_req_i.addr)
                `ACR_ADDR_CTL_ONE: begin
                    state_nxt.rdata = {state_r.eoc, state_r.go, state_r.trig_sel,
                                       state_r.rnd_ctl, state_r.rsv}; // R6
                end
                `ACR_ADDR_CTL_TWO: begin
                    state_nxt.rdata = {state_r.reference, state_r.decimation,
                                       state_r.ch_readback}; // R16
                end
                `ACR_ADDR_RESULT_HIGH: begin
                    state_nxt.rdata = state_r.result[`ACR_RES_HI:`ACR_RES_LO]; // R1
                end
                default: begin
                    state_nxt.rdata = `ACR_BYTE_ZERO;
                end
            endcase
        end

        // reading the high byte acknowledges the result
        if (rd_result_high) begin
            state_nxt.eoc = 1'b0; // R3
        end

        // random generator field returns to done after its single step
        if (rnd_step) begin
            state_nxt.rnd_ctl = `ACR_RND_DONE; // R9
        end

        // control one writes; go is write-one and never stored directly
        if (wr_ctl_one) begin
            state_nxt.trig_sel = bus_req_i.wdata[`ACR_TRIG_HI:`ACR_TRIG_LO]; // R7
            state_nxt.rsv = bus_req_i.wdata[`ACR_RSV_HI:`ACR_RSV_LO];
            if (bus_req_i.wdata[`ACR_RND_HI:`ACR_RND_LO] == `ACR_RND_STEP) begin
                state_nxt.rnd_ctl = `ACR_RND_STEP; // R9
            end
        end

        // control two writes; settings should only change while idle
        if (wr_ctl_two) begin
            state_nxt.reference = bus_req_i.wdata[`ACR_REF_HI:`ACR_REF_LO]; // R10
            state_nxt.decimation = bus_req_i.wdata[`ACR_DEC_HI:`ACR_DEC_LO]; // R11
            state_nxt.end_channel = bus_req_i.wdata[`ACR_CH_HI:`ACR_CH_LO]; // R12
            state_nxt.ch_readback = bus_req_i.wdata[`ACR_CH_HI:`ACR_CH_LO];
        end

        case (state_r.seq)
            acr_pkg::ACR_IDLE: begin
                if (go_start || trig_start) begin
                    state_nxt.go = go_start; // R6
                    state_nxt.cursor = first_channel(state_r.end_channel);
                    state_nxt.conv_start = 1'b1;
                    state_nxt.seq = acr_pkg::ACR_WAIT;
                end
            end
            acr_pkg::ACR_WAIT: begin
                if (conv_res_i.done) begin
                    // mask before storing so both bytes agree
                    state_nxt.result = conv_res_i.value &
                                       resolution_mask(state_r.decimation); // R2
                    state_nxt.eoc = 1'b1; // R3 R4
                    state_nxt.sample_ready = 1'b1;
                    state_nxt.ch_readback = readback_of(state_r.cursor); // R16 R17
                    if (seq_last) begin
                        state_nxt.go = 1'b0; // R18
                        if (state_r.trig_sel == `ACR_TRIG_FULL) begin
                            // restart straight away without a dead cycle
                            state_nxt.cursor = first_channel(state_r.end_channel); // R19
                            state_nxt.conv_start = 1'b1;
                        end else begin
                            state_nxt.seq = acr_pkg::ACR_IDLE;
                        end
                    end else begin
                        state_nxt.cursor = state_r.cursor + `ACR_CH_STEP; // R13 R14
                        state_nxt.conv_start = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt.seq = acr_pkg::ACR_IDLE;
            end
        endcase
    end

    // single register stage for all state
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_r.seq <= acr_pkg::ACR_IDLE;
            state_r.eoc <= 1'b0;
            state_r.go <= 1'b0;
            state_r.trig_sel <= `ACR_TRIG_RST;
            state_r.rnd_ctl <= `ACR_RND_RST;
            state_r.rsv <= `ACR_RSV_RST;
            state_r.reference <= `ACR_REF_RST;
            state_r.decimation <= `ACR_DEC_RST;
            state_r.end_channel <= `ACR_CH_RST;
            state_r.ch_readback <= `ACR_CH_RST;
            state_r.cursor <= `ACR_CH_RST;
            state_r.result <= `ACR_RESULT_RST;
            state_r.rdata <= `ACR_BYTE_ZERO;
            state_r.pin_sync <= 3'h0;
            state_r.pin_level <= 1'b0;
            state_r.conv_start <= 1'b0;
            state_r.sample_ready <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // random generator steps once per request
    acr_lfsr #(
        .WIDTH(`ACR_LFSR_WIDTH),
        .UNROLL(LFSR_UNROLL),
        .SEED(LFSR_SEED),
        .TAPS(LFSR_TAPS)
    ) u_lfsr (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .step_i(rnd_step),
        .value_o(random_o)
    );

    // outputs straight from state
    assign rdata_o = state_r.rdata;
    assign conv_cfg_o.reference = state_r.reference; // R10
    assign conv_cfg_o.decimation = state_r.decimation; // R11
    assign conv_cfg_o.channel = state_r.cursor;
    assign conv_start_o = state_r.conv_start;
    assign seq_busy_o = (state_r.seq == acr_pkg::ACR_WAIT);
    assign sample_ready_o = state_r.sample_ready;
    assign result_o = state_r.result;

endmodule : acr_top

// file: rtl/acr_consts.svh
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// register addresses on the special-function bus
`define ACR_ADDR_CTL_ONE 8'hB4
`define ACR_ADDR_CTL_TWO 8'hB5
`define ACR_ADDR_RESULT_HIGH 8'hBB

// converter_control_one field positions
`define ACR_EOC_BIT 7
`define ACR_GO_BIT 6
`define ACR_TRIG_HI 5
`define ACR_TRIG_LO 4
`define ACR_RND_HI 3
`define ACR_RND_LO 2
`define ACR_RSV_HI 1
`define ACR_RSV_LO 0

// converter_control_two field positions
`define ACR_REF_HI 7
`define ACR_REF_LO 6
`define ACR_DEC_HI 5
`define ACR_DEC_LO 4
`define ACR_CH_HI 3
`define ACR_CH_LO 0

// result word slice shown in result_high_byte
`define ACR_RES_HI 11
`define ACR_RES_LO 4

// reset values
`define ACR_TRIG_RST 2'h3
`define ACR_RSV_RST 2'h3
`define ACR_RND_RST 2'h0
`define ACR_REF_RST 2'h0
`define ACR_DEC_RST 2'h1
`define ACR_CH_RST 4'h0
`define ACR_RESULT_RST 12'h000
`define ACR_BYTE_ZERO 8'h00

// trigger select codes
`define ACR_TRIG_PIN 2'h0
`define ACR_TRIG_FULL 2'h1
`define ACR_TRIG_TIMER 2'h2
`define ACR_TRIG_GO 2'h3

// random generator control codes
`define ACR_RND_DONE 2'h0
`define ACR_RND_STEP 2'h1

// decimation codes
`define ACR_DEC_64 2'h0
`define ACR_DEC_128 2'h1
`define ACR_DEC_256 2'h2
`define ACR_DEC_512 2'h3

// meaningful result bits per decimation code
`define ACR_RES_BITS_64 7
`define ACR_RES_BITS_128 9
`define ACR_RES_BITS_256 10
`define ACR_RES_BITS_512 12
`define ACR_RES_WIDTH 12

// channel code boundaries
`define ACR_CH_FIRST_SINGLE 4'h0
`define ACR_CH_LAST_SINGLE 4'h7
`define ACR_CH_FIRST_PAIR 4'h8
`define ACR_CH_FIRST_FIXED 4'hC
`define ACR_CH_STEP 4'h1

// random generator defaults
`define ACR_LFSR_WIDTH 16
`define ACR_LFSR_UNROLL 13
`define ACR_LFSR_SEED 16'hFFFF
`define ACR_LFSR_TAPS 16'hB400

`endif

// file: rtl/acr_pkg.sv
package acr_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        ACR_IDLE,
        ACR_WAIT
    } acr_seq_type;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acr_bus_req_type;

    // settings sent to the modulator with each conversion
    typedef struct packed {
        logic [1:0] reference;
        logic [1:0] decimation;
        logic [3:0] channel;
    } acr_conv_cfg_type;

    // conversion-done event from the filter
    typedef struct packed {
        logic done;
        logic [11:0] value;
    } acr_conv_res_type;

    // whole state of the control block
    typedef struct packed {
        acr_seq_type seq;
        logic eoc;
        logic go;
        logic [1:0] trig_sel;
        logic [1:0] rnd_ctl;
        logic [1:0] rsv;
        logic [1:0] reference;
        logic [1:0] decimation;
        logic [3:0] end_channel;
        logic [3:0] ch_readback;
        logic [3:0] cursor;
        logic [11:0] result;
        logic [7:0] rdata;
        logic [2:0] pin_sync;
        logic pin_level;
        logic conv_start;
        logic sample_ready;
    } acr_state_type;

    // state of the random generator
    typedef struct packed {
        logic [15:0] value;
    } acr_lfsr_state_type;

endpackage : acr_pkg

// file: rtl/acr_lfsr.sv
`timescale 1ns/1ns
`include "acr_consts.svh"

module acr_lfsr #(
    parameter int WIDTH = `ACR_LFSR_WIDTH,
    parameter int UNROLL = `ACR_LFSR_UNROLL,
    parameter logic [15:0] SEED = `ACR_LFSR_SEED,
    parameter logic [15:0] TAPS = `ACR_LFSR_TAPS
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic step_i,
    output logic [15:0] value_o
);

    acr_pkg::acr_lfsr_state_type state_r;
    acr_pkg::acr_lfsr_state_type state_nxt;

    // one shift of the feedback register
    function automatic logic [15:0] lfsr_shift(input logic [15:0] v);
        logic fb;
        fb = ^(v & TAPS);
        lfsr_shift = {v[14:0], fb};
    endfunction : lfsr_shift

    // a step applies all unrolled shifts in one clock
    always_comb begin
        state_nxt = state_r;
        if (step_i) begin
            for (int i = 0; i < UNROLL; i++) begin
                state_nxt.value = lfsr_shift(state_nxt.value);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_r.value <= SEED;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign value_o = state_r.value;

endmodule : acr_lfsr

// file: testbench/acr_properties.sv
`timescale 1ns/1ns

module acr_properties (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire acr_pkg::acr_bus_req_type bus_req_i,
    input wire logic [7:0] rdata_o,
    input wire logic external_trigger_pin_i,
    input wire logic timer_compare_i,
    input wire acr_pkg::acr_conv_res_type conv_res_i,
    input wire acr_pkg::acr_conv_cfg_type conv_cfg_o,
    input wire logic conv_start_o,
    input wire logic seq_busy_o,
    input wire logic sample_ready_o,
    input wire logic [11:0] result_o,
    input wire logic [15:0] random_o
);
    // result bits below the resolution of each decimation code
    localparam logic [11:0] LOW_M [4] = '{12'h01F, 12'h007, 12'h003, 12'h000};

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    AST_RD_IDLE: assert property (!$past(bus_req_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse longer than one cycle");
    AST_NO_RESTART: assert property (seq_busy_o && !conv_res_i.done |=> !conv_start_o)
        else $error("start while a conversion runs");
    AST_BUSY_HOLD: assert property (seq_busy_o && !conv_res_i.done |=> seq_busy_o)
        else $error("busy dropped before done");
    AST_READY: assert property (sample_ready_o == $past(conv_res_i.done && seq_busy_o))
        else $error("sample ready not tied to an accepted done");
    AST_RESULT: assert property (sample_ready_o |->
        result_o == ($past(conv_res_i.value) & ~LOW_M[conv_cfg_o.decimation]))
        else $error("result not the masked conversion value");
    AST_FIRST_CH: assert property (conv_start_o && !$past(seq_busy_o) |->
        conv_cfg_o.channel inside {4'h0, 4'h8, [4'hC:4'hF]})
        else $error("sequence began on a wrong channel");
    AST_LFSR_CAUSE: assert property ($changed(random_o) |-> $past(bus_req_i.wr, 2)
        && $past(bus_req_i.addr, 2) == 8'hB4 && $past(bus_req_i.wdata[3:2], 2) == 2'h1)
        else $error("random value moved without a step request");
endmodule : acr_properties

bind acr_top acr_properties i_props (.sys_clk_i, .reset_i, .bus_req_i, .rdata_o,
    .external_trigger_pin_i, .timer_compare_i, .conv_res_i, .conv_cfg_o,
    .conv_start_o, .seq_busy_o, .sample_ready_o, .result_o, .random_o);

// file: testbench/testbench.sv
`timescale 1ns/1ns
`include "acr_consts.svh"

module testbench;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    acr_pkg::acr_bus_req_type req = '0;
    acr_pkg::acr_conv_res_type res = '0;
    logic pin = 1'b0;
    logic tmr = 1'b0;
    logic [7:0] rdata_o;
    acr_pkg::acr_conv_cfg_type conv_cfg_o;
    logic conv_start_o;
    logic seq_busy_o;
    logic sample_ready_o;
    logic [11:0] result_o;
    logic [15:0] random_o;
    logic [7:0] exp_q [$];
    logic rd_q = 1'b0;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int n_starts = 0;
    int taken = 0;
    logic [11:0] last;
    logic [15:0] lf;
    logic [3:0] e;
    logic [1:0] rf;
    logic [1:0] dc;
    logic [3:0] ends [5] = '{4'h2, 4'h7, 4'hB, 4'hC, 4'hF};

    always #2 sys_clk_i = ~sys_clk_i;

    acr_top i_dut (.sys_clk_i, .reset_i, .bus_req_i(req), .rdata_o,
        .external_trigger_pin_i(pin), .timer_compare_i(tmr), .conv_res_i(res),
        .conv_cfg_o, .conv_start_o, .seq_busy_o, .sample_ready_o, .result_o, .random_o);

    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // idle cycle after each strobe, so no strobe is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_i);
        req <= '0;
        @(posedge sys_clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk_i);
        req <= '0;
        @(posedge sys_clk_i);
    endtask : rd

    // a start pulse may come while a write task still runs, so count them
    task automatic wait_start();
        for (int k = 0; k < 40; k++) begin
            if (n_starts > taken) begin
                taken++;
                return;
            end
            @(posedge sys_clk_i);
        end
        check("start", 16'h0, 16'h1);
    endtask : wait_start

    // every start seen so far must already have been served
    task automatic no_start();
        repeat (8) @(posedge sys_clk_i);
        check("start", 16'(n_starts - taken), 16'h0);
    endtask : no_start

    // count start pulses mid-cycle, away from the edge that launches them
    always @(negedge sys_clk_i) begin
        if (conv_start_o === 1'b1)
            n_starts++;
    end

    function automatic logic [7:0] hi(input logic [11:0] v, input logic [1:0] d);
        logic [11:0] m;
        m = d == 2'h0 ? 12'hFE0 : d == 2'h1 ? 12'hFF8 : d == 2'h2 ? 12'hFFC : 12'hFFF;
        return 8'((v & m) >> 4);
    endfunction : hi

    function automatic logic [15:0] lstep(input logic [15:0] v);
        for (int k = 0; k < `ACR_LFSR_UNROLL; k++)
            v = {v[14:0], ^(v & `ACR_LFSR_TAPS)};
        return v;
    endfunction : lstep

    // plays the filter; rewrites control one mid-run to prove it cannot restart
    task automatic serve(input logic [3:0] ec, input logic [7:0] ctl, input logic [7:0] rw);
        int f;
        f = ec < 4'h8 ? 0 : (ec < 4'hC ? 8 : int'(ec));
        for (int i = f; i <= int'(ec); i++) begin
            wait_start();
            check("chan", 16'(conv_cfg_o.channel), 16'(i));
            check("cfg", 16'({conv_cfg_o.reference, conv_cfg_o.decimation}), 16'({rf, dc}));
            rd(8'hB4, i == f ? ctl : {1'b1, rw[6:0]});
            if (i == f)
                wr(8'hB4, rw);
            repeat ($urandom_range(3, 0)) @(posedge sys_clk_i);
            last = 12'($urandom);
            res <= '{1'b1, last};
            @(posedge sys_clk_i);
            res <= '0;
        end
        @(posedge sys_clk_i);
    endtask : serve

    // oldest noted value against the data standing after the strobe
    always @(posedge sys_clk_i) begin
        rd_q <= req.rd;
    end

    // read data looked at mid-cycle, while it stands
    always @(negedge sys_clk_i) begin
        if (rd_q && exp_q.size() > 0)
            check("rdata", 16'(rdata_o), 16'(exp_q.pop_front()));
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        void'($urandom(5319));
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        check("random", random_o, `ACR_LFSR_SEED);
        rd(8'hB4, 8'h33);
        rd(8'hB5, 8'h10);
        wr(8'hBB, 8'($urandom));
        rd(8'hBB, 8'h00);
        rd(8'hC0, 8'h00);
        lf = `ACR_LFSR_SEED;
        // each step is followed by a reserved code that must be ignored
        repeat (2) begin
            wr(8'hB4, 8'h37);
            wr(8'hB4, 8'h3B);
            lf = lstep(lf);
            check("random", random_o, lf);
            rd(8'hB4, 8'h33);
        end
        // go sequences over every decimation and each kind of end channel
        for (int n = 0; n < 5; n++) begin
            e = ends[n];
            dc = 2'(n);
            rf = 2'(3 - n);
            wr(8'hB5, {rf, dc, e});
            rd(8'hB5, {rf, dc, e});
            wr(8'hB4, 8'h73);
            serve(e, 8'h73, 8'h73);
            rd(8'hB4, 8'hB3);
            rd(8'hBB, hi(last, dc));
            rd(8'hB4, 8'h33);
            rd(8'hB5, {rf, dc, e < 4'hC ? e + 4'h1 : e});
        end
        // go refused under timer select, then timer, pin and full-speed starts
        wr(8'hB5, {rf, dc, 4'h1});
        wr(8'hB4, 8'h63);
        no_start();
        rd(8'hB4, 8'h23);
        tmr <= 1'b1;
        @(posedge sys_clk_i);
        tmr <= 1'b0;
        serve(4'h1, 8'h23, 8'h23);
        rd(8'hBB, hi(last, dc));
        wr(8'hB4, 8'h03);
        pin <= 1'b1;
        serve(4'h1, 8'h03, 8'h03);
        pin <= 1'b0;
        rd(8'hBB, hi(last, dc));
        wr(8'hB4, 8'h13);
        serve(4'h1, 8'h13, 8'h13);
        serve(4'h1, 8'h93, 8'h33);
        no_start();
        rd(8'hB4, 8'hB3);
        test_done();
    end
endmodule : testbench
